/* logic/mua_top.sv */
// Purpose: user command slots and link monitor of a management bus master
// Assumes: register port strobes are one cycle, never both at once
// Notes:   MDC is made here by dividing the core clock
`timescale 1ns/1ns
`default_nettype none
module mua_top (
    input  wire logic        REF_CLK_IN,  // core clock
    input  wire logic        RESET_N_IN,  // async reset, low
    input  wire logic [7:0]  ADDR_IN,     // register byte address
    input  wire logic [31:0] WDATA_IN,    // write data
    input  wire logic        WR_IN,       // write strobe
    input  wire logic        RD_IN,       // read strobe
    output var  logic [31:0] RDATA_OUT,   // read data, next cycle
    output var  logic        IRQ_OUT,     // interrupt level
    output var  logic        MDC_OUT,     // management clock
    input  wire logic        MDIO_IN,     // data pin, input
    output var  logic        MDIO_OUT,    // data pin, output
    output var  logic        MDIO_OE_OUT  // data pin, drive enable
);
    import mua_pkg::*;

    // decode one register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ********************************
    // declarations
    // ********************************
    logic        go_r   [2];
    logic        dir_r  [2];
    logic        ack_r  [2];
    logic [4:0]  reg_r  [2];
    logic [4:0]  phy_r  [2];
    logic [15:0] data_r [2];
    logic [7:0]  link_sel_r;
    logic        enable_r;
    logic [2:0]  stat_r;
    logic [2:0]  stat_nxt;
    logic [2:0]  mask_r;
    logic        link_up_r;
    logic        s1_r;
    logic        s2_r;
    logic        s3_r;
    logic        mdio_q_r;
    mua_state_e  state_r;
    logic [2:0]  phase_r;
    logic [5:0]  bit_r;
    logic [63:0] frame_r;
    logic [1:0]  sel_r;
    logic        wr_op_r;
    logic        got_ack_r;
    logic [15:0] rd_sh_r;
    logic [31:0] rd_nxt;
    logic [2:0]  events;

    // ********************************
    // pin input synchroniser
    // ********************************
    // three stages; accept a level once stages two and three agree
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            s1_r     <= 1'b1;
            s2_r     <= 1'b1;
            s3_r     <= 1'b1;
            mdio_q_r <= 1'b1;
        end else begin
            s1_r <= MDIO_IN;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                mdio_q_r <= s3_r;
            end
        end
    end

    // ********************************
    // command slots
    // ********************************
    // software writes, launch and completion per slot
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            for (int i = 0; i < 2; i++) begin
                go_r[i]   <= 1'b0;
                dir_r[i]  <= 1'b0;
                ack_r[i]  <= 1'b0;
                reg_r[i]  <= 5'h00;
                phy_r[i]  <= 5'h00;
                data_r[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                // pending slot ignores every write
                if (WR_IN && !go_r[i] &&
                    hit(ADDR_IN, (i == 0) ? OFS_SLOT_A : OFS_SLOT_B)) begin
                    go_r[i]   <= WDATA_IN[POS_GO] & enable_r;
                    dir_r[i]  <= WDATA_IN[POS_DIR];
                    ack_r[i]  <= WDATA_IN[POS_ACK];
                    reg_r[i]  <= WDATA_IN[POS_REG_HI:POS_REG_LO];
                    phy_r[i]  <= WDATA_IN[POS_PHY_HI:POS_PHY_LO];
                    data_r[i] <= WDATA_IN[15:0];
                end
                // access over: clear go, store read result
                if (state_r == ST_FINISH && sel_r == 2'(i)) begin
                    go_r[i] <= 1'b0;
                    if (!wr_op_r) begin
                        ack_r[i] <= got_ack_r;
                        if (got_ack_r) begin
                            data_r[i] <= rd_sh_r;
                        end
                    end
                end
            end
        end
    end

    // ********************************
    // control, link select and mask registers
    // ********************************
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            link_sel_r <= RST_LINK_SEL;
            enable_r   <= RST_ENABLE;
            mask_r     <= RST_MASK;
        end else if (WR_IN) begin
            if (hit(ADDR_IN, OFS_LINK_SEL)) begin
                link_sel_r <= {WDATA_IN[7:6], 1'b0, WDATA_IN[4:0]};
            end
            if (hit(ADDR_IN, OFS_CTRL)) begin
                enable_r <= WDATA_IN[POS_ENABLE];
            end
            if (hit(ADDR_IN, OFS_IRQ_MASK)) begin
                mask_r <= WDATA_IN[NUM_EVT-1:0];
            end
        end
    end

    // ********************************
    // frame engine
    // ********************************
    // picks slot a, then slot b, else polls the monitored PHY
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r     <= ST_IDLE;
            phase_r     <= 3'h0;
            bit_r       <= 6'h00;
            frame_r     <= 64'h0;
            sel_r       <= 2'h0;
            wr_op_r     <= 1'b0;
            got_ack_r   <= 1'b0;
            rd_sh_r     <= 16'h0000;
            MDC_OUT     <= 1'b0;
            MDIO_OUT    <= 1'b1;
            MDIO_OE_OUT <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    phase_r   <= 3'h0;
                    bit_r     <= 6'h00;
                    got_ack_r <= 1'b0;
                    if (enable_r) begin
                        state_r     <= ST_SHIFT;
                        MDIO_OE_OUT <= 1'b1;
                        MDIO_OUT    <= PREAMBLE[31];
                        if (go_r[0]) begin
                            sel_r   <= 2'h0;
                            wr_op_r <= dir_r[0];
                            frame_r <= {PREAMBLE, START_CODE,
                                        dir_r[0] ? OP_WRITE : OP_READ,
                                        phy_r[0], reg_r[0],
                                        dir_r[0] ? TA_WRITE : TA_READ,
                                        data_r[0]};
                        end else if (go_r[1]) begin
                            sel_r   <= 2'h1;
                            wr_op_r <= dir_r[1];
                            frame_r <= {PREAMBLE, START_CODE,
                                        dir_r[1] ? OP_WRITE : OP_READ,
                                        phy_r[1], reg_r[1],
                                        dir_r[1] ? TA_WRITE : TA_READ,
                                        data_r[1]};
                        end else begin
                            sel_r   <= SEL_POLL;
                            wr_op_r <= 1'b0;
                            frame_r <= {PREAMBLE, START_CODE, OP_READ,
                                        link_sel_r[4:0], LINK_REG,
                                        TA_READ, 16'hFFFF};
                        end
                    end
                end
                ST_SHIFT: begin
                    phase_r <= phase_r + 3'h1;
                    if (phase_r == PH_RISE) begin
                        MDC_OUT <= 1'b1;
                    end
                    if (phase_r == PH_LAST) begin
                        // sample just before the falling edge
                        phase_r <= 3'h0;
                        MDC_OUT <= 1'b0;
                        if (bit_r == BIT_ACK) begin
                            got_ack_r <= !mdio_q_r;
                        end
                        if (bit_r >= BIT_DATA) begin
                            rd_sh_r <= {rd_sh_r[14:0], mdio_q_r};
                        end
                        if (bit_r == BIT_LAST) begin
                            state_r     <= ST_FINISH;
                            MDIO_OE_OUT <= 1'b0;
                            MDIO_OUT    <= 1'b1;
                        end else begin
                            bit_r       <= bit_r + 6'h01;
                            frame_r     <= {frame_r[62:0], 1'b1};
                            MDIO_OUT    <= frame_r[62];
                            MDIO_OE_OUT <= wr_op_r || (bit_r + 6'h01 < BIT_TA);
                        end
                    end
                end
                ST_FINISH: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************
    // link monitor
    // ********************************
    // keeps the last polled link bit of the monitored PHY
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            link_up_r <= 1'b0;
        end else if (state_r == ST_FINISH && sel_r == SEL_POLL && got_ack_r) begin
            link_up_r <= rd_sh_r[POS_PHY_LINK];
        end
    end

    // ********************************
    // events and interrupt
    // ********************************
    // done events per slot, link change only when enabled
    always_comb begin
        events = 3'h0;
        if (state_r == ST_FINISH) begin
            events[EVT_DONE_A] = (sel_r == 2'h0);
            events[EVT_DONE_B] = (sel_r == 2'h1);
            events[EVT_LINK]   = (sel_r == SEL_POLL) && got_ack_r &&
                                 (rd_sh_r[POS_PHY_LINK] != link_up_r) &&
                                 link_sel_r[POS_LINK_IE];
        end
        // write one clears; a new event in the same cycle wins
        stat_nxt = stat_r;
        if (WR_IN && hit(ADDR_IN, OFS_IRQ_STAT)) begin
            stat_nxt = stat_r & ~WDATA_IN[NUM_EVT-1:0];
        end
        stat_nxt = stat_nxt | events;
    end

    // sticky status and masked interrupt level
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            stat_r  <= 3'h0;
            IRQ_OUT <= 1'b0;
        end else begin
            stat_r  <= stat_nxt;
            IRQ_OUT <= |(stat_nxt & mask_r);
        end
    end

    // ********************************
    // read port
    // ********************************
    always_comb begin
        rd_nxt = 32'h0;
        case (ADDR_IN)
            OFS_SLOT_A, OFS_SLOT_B: begin
                for (int i = 0; i < 2; i++) begin
                    if (hit(ADDR_IN, (i == 0) ? OFS_SLOT_A : OFS_SLOT_B)) begin
                        rd_nxt = {go_r[i], dir_r[i], ack_r[i], 3'h0,
                                  reg_r[i], phy_r[i], data_r[i]};
                    end
                end
            end
            OFS_LINK_SEL: rd_nxt = {24'h0, link_sel_r};
            OFS_CTRL: begin
                rd_nxt[POS_ENABLE]  = enable_r;
                rd_nxt[POS_LINK_UP] = link_up_r;
            end
            OFS_IRQ_STAT: rd_nxt = {29'h0, stat_r};
            OFS_IRQ_MASK: rd_nxt = {29'h0, mask_r};
            default: rd_nxt = 32'h0;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RDATA_OUT <= 32'h0;
        end else begin
            RDATA_OUT <= RD_IN ? rd_nxt : 32'h0;
        end
    end
endmodule : mua_top
`default_nettype wire

/* shared/mua_pkg.sv */
// Purpose: constants for the user command and link monitor registers
// Assumes: 25 MHz core clock, 32-bit register port
// Notes:   offsets are byte addresses on the register port
package mua_pkg;
    // ********************************
    // register offsets
    // ********************************
    localparam logic [7:0] OFS_SLOT_A   = 8'h00;
    localparam logic [7:0] OFS_LINK_SEL = 8'h04;
    localparam logic [7:0] OFS_SLOT_B   = 8'h08;
    localparam logic [7:0] OFS_CTRL     = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // ********************************
    // command slot fields
    // ********************************
    localparam int POS_GO      = 31;
    localparam int POS_DIR     = 30;
    localparam int POS_ACK     = 29;
    localparam int POS_REG_HI  = 25;
    localparam int POS_REG_LO  = 21;
    localparam int POS_PHY_HI  = 20;
    localparam int POS_PHY_LO  = 16;
    // ********************************
    // link select, control, status fields
    // ********************************
    localparam int POS_SRC_SEL = 7;
    localparam int POS_LINK_IE = 6;
    localparam int POS_ENABLE  = 0;
    localparam int POS_LINK_UP = 8;
    localparam int EVT_DONE_A  = 0;
    localparam int EVT_DONE_B  = 1;
    localparam int EVT_LINK    = 2;
    localparam int NUM_EVT     = 3;
    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0]  RST_LINK_SEL = 8'h00;
    localparam logic        RST_ENABLE   = 1'b0;
    localparam logic [2:0]  RST_MASK     = 3'h0;
    // ********************************
    // frame layout and link timing
    // ********************************
    localparam int CLK_PERIOD_NS  = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int MDC_HALF_CYC   = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] PH_RISE = 3'(MDC_HALF_CYC - 1);
    localparam logic [2:0] PH_LAST = 3'(2 * MDC_HALF_CYC - 1);
    localparam logic [5:0] BIT_TA      = 6'h2E;
    localparam logic [5:0] BIT_ACK     = 6'h2F;
    localparam logic [5:0] BIT_DATA    = 6'h30;
    localparam logic [5:0] BIT_LAST    = 6'h3F;
    localparam logic [31:0] PREAMBLE   = 32'hFFFFFFFF;
    localparam logic [1:0]  START_CODE = 2'h1;
    localparam logic [1:0]  OP_READ    = 2'h2;
    localparam logic [1:0]  OP_WRITE   = 2'h1;
    localparam logic [1:0]  TA_WRITE   = 2'h2;
    localparam logic [1:0]  TA_READ    = 2'h3;
    localparam logic [4:0]  LINK_REG   = 5'h01;
    localparam int          POS_PHY_LINK = 2;
    localparam logic [1:0]  SEL_POLL   = 2'h2;
    typedef enum {ST_IDLE, ST_SHIFT, ST_FINISH} mua_state_e;
endpackage : mua_pkg

/* tb/mua_top_assertions.sv */
// Purpose: port checks for the command slot block
// Assumes: enable and mask change only by bus writes
// Notes:   fr_cnt counts cycles since drive enable rose
`timescale 1ns/1ns
`default_nettype none
module mua_top_assertions
    import mua_pkg::*;
(
    input wire logic        REF_CLK_IN,  // clock
    input wire logic        RESET_N_IN,  // reset, low
    input wire logic [7:0]  ADDR_IN,     // address
    input wire logic [31:0] WDATA_IN,    // write data
    input wire logic        WR_IN,       // write strobe
    input wire logic        IRQ_OUT,     // interrupt
    input wire logic        MDC_OUT,     // link clock
    input wire logic        MDIO_OUT,    // line value
    input wire logic        MDIO_OE_OUT  // line drive
);
    logic       oe_r;
    logic [9:0] fr_cnt;
    logic       en_r;
    logic [2:0] msk_r;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // frame cycle counter
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            oe_r <= 1'b0;
            fr_cnt <= 10'h000;
        end else begin
            oe_r <= MDIO_OE_OUT;
            fr_cnt <= (MDIO_OE_OUT && !oe_r) ? 10'h001 : (fr_cnt != 10'h000 && fr_cnt < 10'h3FF) ? fr_cnt + 10'h001 : 10'h000;
        end
    end
    // shadow of enable and mask
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            en_r <= RST_ENABLE;
            msk_r <= RST_MASK;
        end else if (WR_IN && ADDR_IN == OFS_CTRL) begin
            en_r <= WDATA_IN[POS_ENABLE];
        end else if (WR_IN && ADDR_IN == OFS_IRQ_MASK) begin
            msk_r <= WDATA_IN[2:0];
        end
    end
    mdc_high_a: assert property ($rose(MDC_OUT) |-> MDC_OUT [*4] ##1 !MDC_OUT)
        else $error("clock high phase wrong");
    mdc_low_a: assert property ($fell(MDC_OUT) |-> !MDC_OUT [*4])
        else $error("clock low phase short");
    data_stable_a: assert property (MDC_OUT && MDIO_OE_OUT |-> $stable(MDIO_OUT))
        else $error("line moved while clock high");
    preamble_a: assert property (MDIO_OE_OUT && fr_cnt != 10'h000 && fr_cnt < 10'h100 |-> MDIO_OUT)
        else $error("preamble bit low");
    start_code_a: assert property (fr_cnt == 10'd260 |-> !MDIO_OUT ##8 MDIO_OUT)
        else $error("start code wrong");
    read_turn_a: assert property (fr_cnt == 10'd284 && !MDIO_OUT |-> ##88 !MDIO_OE_OUT)
        else $error("read frame kept the line");
    write_drive_a: assert property (fr_cnt == 10'd284 && MDIO_OUT |->
        ##88 (MDIO_OE_OUT && MDIO_OUT) ##8 (MDIO_OE_OUT && !MDIO_OUT) ##128 MDIO_OE_OUT)
        else $error("write turnaround wrong");
    frame_enable_a: assert property ($rose(MDIO_OE_OUT) |-> $past(en_r) || $past(en_r, 2))
        else $error("frame while disabled");
    irq_mask_a: assert property (msk_r == 3'h0 && $past(msk_r) == 3'h0 |-> !IRQ_OUT)
        else $error("interrupt while masked");
    cover property (fr_cnt == 10'd284 && !MDIO_OUT);
    cover property (fr_cnt == 10'd284 && MDIO_OUT);
    cover property ($rose(IRQ_OUT));
endmodule : mua_top_assertions
bind mua_top mua_top_assertions u_chk (.REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .IRQ_OUT(IRQ_OUT), .MDC_OUT(MDC_OUT), .MDIO_OUT(MDIO_OUT),
    .MDIO_OE_OUT(MDIO_OE_OUT));
`default_nettype wire

/* tb/mua_phy_model.sv */
// Purpose: behavioural phy on the management line
// Assumes: a frame begins when the master drive enable rises
// Notes:   answers reads only at its own address
`timescale 1ns/1ns
`default_nettype none
module mua_phy_model
    import mua_pkg::*;
#(
    parameter logic [4:0] PHY_ADR = 5'h03  // answering address
)(
    input  wire logic        mdc_in,      // link clock
    input  wire logic        mdio_in,     // resolved line
    input  wire logic        oe_in,       // master drive
    input  wire logic        link_in,     // link state
    output var  logic        mdio_out,    // phy line value
    output var  logic        mdio_oe_out, // phy drives
    output var  logic [25:0] wr_seen_out  // last write seen
);
    logic [63:0] sh = 64'h0;
    logic [1:0]  rop = 2'h0;
    logic [4:0]  rphy;
    logic [15:0] rdat;
    int          n = 0;
    initial mdio_out = 1'b1;
    initial mdio_oe_out = 1'b0;
    initial wr_seen_out = 26'h0;
    // master takes the line: new frame
    always @(posedge oe_in) begin
        n = 0;
        rop = 2'h0;
    end
    // shift in master bits and decode the header
    always @(posedge mdc_in) begin
        sh = {sh[62:0], mdio_in};
        n = n + 1;
        if (n == 46) begin
            rop = sh[11:10];
            rphy = sh[9:5];
            rdat = (sh[4:0] == LINK_REG) ? {13'h0, link_in, 2'h0} : {sh[4:0], sh[9:5], 6'h2A};
        end
        if (n == 64 && sh[29:28] == OP_WRITE) wr_seen_out = {sh[27:18], sh[15:0]};
    end
    // read answer: ack low then data msb first
    always @(negedge mdc_in) begin
        mdio_oe_out = rop == OP_READ && rphy == PHY_ADR && n >= 47 && n <= 63;
        mdio_out = (n == 47) ? 1'b0 : rdat[(63 - n) & 15];
    end
endmodule : mua_phy_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the command slot block
// Assumes: phy model at address 3, none at 7
// Notes:   reads are noted in a queue and checked one cycle later
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import mua_pkg::*;
    typedef struct {logic [31:0] e; logic [31:0] m; string n;} mua_note_s;
    logic        clk, rst_n, wr, rd, rd_q, link, irq, mdc, mdo, moe, pdo, poe;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [25:0] wr_seen;
    logic [4:0]  rg, rb;
    logic [15:0] d;
    int          miscompares = 0, n_tests = 0, cyc = 0;
    mua_note_s   q[$], nt;
    wire         line = moe ? mdo : (poe ? pdo : 1'b1); // pulled up
    mua_top dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .MDC_OUT(mdc), .MDIO_IN(line), .MDIO_OUT(mdo),
        .MDIO_OE_OUT(moe));
    mua_phy_model phy (.mdc_in(mdc), .mdio_in(line), .oe_in(moe), .link_in(link), .mdio_out(pdo),
        .mdio_oe_out(poe), .wr_seen_out(wr_seen));
    // compare one result
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read; m of zero means no compare
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        q.push_back('{e, m, nm});
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : rd_reg
    task automatic wait_go(input logic [7:0] a);
        repeat (100) begin
            rd_reg(a, 32'h0, 32'h0, "");
            if (v[POS_GO] === 1'b0) break;
            repeat (20) @(posedge clk);
        end
    endtask : wait_go
    function automatic logic [31:0] cmd(input logic g, w, k, input logic [4:0] r, p, input logic [15:0] x);
        return {g, w, k, 3'h0, r, p, x};
    endfunction : cmd
    function automatic logic [15:0] pdat(input logic [4:0] r, p);
        return (r == LINK_REG) ? {13'h0, link, 2'h0} : {r, p, 6'h2A};
    endfunction : pdat
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // read result monitor and hang limit
    always @(posedge clk) begin
        rd_q <= rd;
        cyc++;
        if (rd_q && q.size() > 0) begin
            nt = q.pop_front();
            if (nt.m != 32'h0) chk(nt.n, nt.e & nt.m, rdata & nt.m);
        end
        if (cyc == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, wr, rd, link, addr, wdata} = '0;
        void'($urandom(15));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_LINK_SEL, 32'h0, 32'hFFFFFFFF, "link_sel");
        rd_reg(OFS_SLOT_A, 32'h0, 32'hFFFFFFFF, "slot_a");
        rd_reg(8'h1C, 32'h0, 32'hFFFFFFFF, "unmapped");
        d = 16'($urandom);
        rg = 5'($urandom);
        rb = 5'($urandom);
        wr_reg(OFS_SLOT_A, cmd(1, 1, 0, rg, 5'h03, d));
        rd_reg(OFS_SLOT_A, cmd(0, 1, 0, rg, 5'h03, d), 32'hFFFFFFFF, "slot_a");
        $display("test disabled launch done");
        wr_reg(OFS_IRQ_MASK, 32'h3);
        wr_reg(OFS_CTRL, 32'h1);
        rd_reg(OFS_IRQ_MASK, 32'h3, 32'hFFFFFFFF, "mask");
        rd_reg(OFS_CTRL, 32'h1, 32'h1, "enable");
        wr_reg(OFS_SLOT_A, cmd(1, 1, 0, rg, 5'h03, d));
        wr_reg(OFS_SLOT_A, cmd(0, 0, 0, ~rg, 5'h00, ~d));
        wr_reg(OFS_SLOT_B, cmd(1, 0, 0, rb, 5'h03, 16'h0));
        rd_reg(OFS_SLOT_A, cmd(1, 1, 0, rg, 5'h03, d), 32'hFFFFFFFF, "slot_a");
        wait_go(OFS_SLOT_A);
        chk("phy_write", {6'h0, 5'h03, rg, d}, {6'h0, wr_seen});
        rd_reg(OFS_SLOT_A, cmd(0, 1, 0, rg, 5'h03, d), 32'hFFFFFFFF, "slot_a");
        wait_go(OFS_SLOT_B);
        rd_reg(OFS_SLOT_B, cmd(0, 0, 1, rb, 5'h03, pdat(rb, 5'h03)), 32'hFFFFFFFF, "slot_b");
        rd_reg(OFS_IRQ_STAT, 32'h3, 32'h3, "status");
        chk("irq", 32'h1, {31'h0, irq});
        $display("test slots done");
        wr_reg(OFS_SLOT_B, cmd(1, 0, 0, rb, 5'h07, 16'h1234));
        wait_go(OFS_SLOT_B);
        rd_reg(OFS_SLOT_B, cmd(0, 0, 0, rb, 5'h07, 16'h1234), 32'hFFFFFFFF, "slot_b");
        wr_reg(OFS_IRQ_MASK, 32'h0);
        wr_reg(OFS_IRQ_STAT, 32'h7);
        rd_reg(OFS_IRQ_STAT, 32'h0, 32'h3, "status");
        chk("irq", 32'h0, {31'h0, irq});
        $display("test absent phy done");
        wr_reg(OFS_SLOT_A, cmd(0, 0, 0, rg, 5'h03, d));
        link = 1'b1;
        wr_reg(OFS_LINK_SEL, 32'h03);
        repeat (1200) @(posedge clk);
        rd_reg(OFS_SLOT_A, cmd(0, 0, 0, rg, 5'h03, d), 32'hFFFFFFFF, "slot_a");
        rd_reg(OFS_IRQ_STAT, 32'h0, 32'h4, "status");
        rd_reg(OFS_CTRL, 32'h100, 32'h100, "link_up");
        wr_reg(OFS_LINK_SEL, 32'h43);
        wr_reg(OFS_IRQ_MASK, 32'h4);
        link = 1'b0;
        repeat (1500) begin
            @(posedge clk);
            if (irq === 1'b1) break;
        end
        rd_reg(OFS_IRQ_STAT, 32'h4, 32'h4, "status");
        rd_reg(OFS_CTRL, 32'h0, 32'h100, "link_up");
        chk("irq", 32'h1, {31'h0, irq});
        $display("test link monitor done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
